// ==== dv/agg_core_model.sv ====
// Purpose: behavioural core interrupt controller facing the group requests
// Assumes: requests are levels on core_clk
// Notes: keeps every group that asserted pending until told to forget
`default_nettype none
module agg_core_model
	import agg_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire agg_grp_t core_req_r,
	input wire logic forget,
	output agg_grp_t seen_r
);
	timeunit 1ns;
	timeprecision 1ps;
	// level requests latch as pending, like a real controller would
	always_ff @(posedge core_clk) begin
		if (srst || forget) begin
			seen_r <= '0;
		end else begin
			seen_r <= seen_r | core_req_r;
		end
	end
endmodule
`default_nettype wire

// ==== dv/test_agg_top.sv ====
// Purpose: self-checking bench of the interrupt group aggregator
// Assumes: register port strobes driven right after rising edges
// Notes: every group visited once, first and last with corner masks
`include "agg_consts.svh"
`default_nettype none
module test_agg_top
	import agg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int EVW = `AGG_GRP_NUM * `AGG_SRC_W;
	// group 0 loses bits 7:4 as unassigned and bit 30 as an absent pin
	localparam logic [EVW-1:0] TB_ASSIGNED = ~EVW'(32'h000000f0);
	localparam logic [EVW-1:0] TB_PIN = ~EVW'(32'h40000000);
	logic core_clk = 1'b0;
	logic srst = 1'b1;
	agg_addr_t reg_addr = '0;
	agg_data_t reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	agg_data_t reg_rdata_r;
	logic [EVW-1:0] src_event = '0;
	agg_grp_t core_req_r;
	logic irq;
	logic forget = 1'b0;
	agg_grp_t seen_r;
	int n_errors = 0;
	int check_count = 0;
	int seed = 32'h9fb6;
	// ****************************************
	// design and far side
	// ****************************************
	agg_top #(.ASSIGNED_MASK(TB_ASSIGNED), .PIN_MASK(TB_PIN))
	agg_top_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.src_event(src_event), .core_req_r(core_req_r), .irq(irq));
	agg_core_model agg_core_model_inst (.core_clk(core_clk), .srst(srst),
		.core_req_r(core_req_r), .forget(forget), .seen_r(seen_r));
	// 250 MHz
	initial begin
		forever #2 core_clk = ~core_clk;
	end
	// ****************************************
	// tasks and expectation functions
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk_word(input string what, input agg_data_t exp, input agg_data_t got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_bit(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask
	// one-cycle strobes; the caller's next task waits for a fresh edge
	task automatic wr(input agg_addr_t a, input agg_data_t d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input agg_addr_t a, output agg_data_t d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_r;
	endtask
	task automatic rd_chk(input string what, input agg_addr_t a, input agg_data_t exp);
		agg_data_t d;
		rd(a, d);
		chk_word(what, exp, d);
	endtask
	// let a few edges pass so registered outputs settle
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	function automatic agg_addr_t grp_base(input int gi);
		return agg_addr_t'(gi * `AGG_GRP_STRIDE);
	endfunction
	function automatic agg_data_t blk_bit(input int gi);
		return agg_data_t'(1) << (gi + `AGG_VEC_LSB);
	endfunction
	// bits of a group that exist in this build; the rest must read zero
	function automatic agg_src_t impl_bits(input int gi);
		return TB_ASSIGNED[gi*`AGG_SRC_W +: `AGG_SRC_W] & TB_PIN[gi*`AGG_SRC_W +: `AGG_SRC_W];
	endfunction
	// ****************************************
	// one group walked through its registers
	// ****************************************
	task automatic one_group(input int gi, input agg_src_t m, input agg_data_t e,
			input agg_data_t c);
		agg_addr_t b;
		agg_src_t en;
		logic req;
		agg_src_t mk;
		b = grp_base(gi);
		en = e[`AGG_SRC_W-1:0] & impl_bits(gi);
		mk = m & impl_bits(gi);
		@(posedge core_clk);
		src_event <= EVW'(m) << (gi * `AGG_SRC_W);
		@(posedge core_clk);
		src_event <= '0;
		rd_chk("source", b + `AGG_OFF_SRC, {1'b0, mk});
		wr(b + `AGG_OFF_RESULT, '1);
		rd_chk("result disabled", b + `AGG_OFF_RESULT, '0);
		wr(b + `AGG_OFF_EN_SET, e);
		wr(b + `AGG_OFF_EN_SET, '0);
		rd_chk("enable set", b + `AGG_OFF_EN_SET, {1'b0, en});
		rd_chk("result", b + `AGG_OFF_RESULT, {1'b0, mk & en});
		en = en & ~c[`AGG_SRC_W-1:0];
		wr(b + `AGG_OFF_EN_CLR, c);
		wr(b + `AGG_OFF_EN_CLR, '0);
		rd_chk("enable clear", b + `AGG_OFF_EN_CLR, {1'b0, en});
		rd_chk("source kept", b + `AGG_OFF_SRC, {1'b0, mk});
		req = |(mk & en);
		chk_word("req idle", '0, agg_data_t'(core_req_r));
		wr(`AGG_BLK_EN_SET, blk_bit(gi));
		// zeros written to either block port must leave the enable alone
		wr(`AGG_BLK_EN_SET, '0);
		wr(`AGG_BLK_EN_CLR, '0);
		settle(1);
		chk_word("req", agg_data_t'(req) << gi, agg_data_t'(core_req_r));
		rd_chk("block enable", `AGG_BLK_EN_SET, blk_bit(gi));
		rd_chk("vector", `AGG_BLK_VECTOR, req ? blk_bit(gi) : '0);
		rd_chk("irq status", `AGG_IRQ_STATUS, req ? blk_bit(gi) : '0);
		chk_bit("irq masked", 1'b0, irq);
		wr(`AGG_IRQ_MASK, blk_bit(gi));
		settle(2);
		chk_bit("irq", req, irq);
		wr(`AGG_IRQ_STATUS, blk_bit(gi));
		settle(2);
		chk_bit("irq cleared", 1'b0, irq);
		chk_word("model seen", agg_data_t'(req) << gi, agg_data_t'(seen_r));
		wr(`AGG_BLK_EN_CLR, blk_bit(gi));
		settle(1);
		chk_word("req off", '0, agg_data_t'(core_req_r));
		rd_chk("vector off", `AGG_BLK_VECTOR, '0);
		wr(b + `AGG_OFF_SRC, {1'b0, m});
		rd_chk("source clear", b + `AGG_OFF_SRC, '0);
		wr(b + `AGG_OFF_EN_CLR, '1);
		wr(`AGG_IRQ_MASK, '0);
		@(posedge core_clk);
		forget <= 1'b1;
		@(posedge core_clk);
		forget <= 1'b0;
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		// reset values, reserved places and an unmapped address read zero
		for (int k = 0; k < 4; k++) begin
			rd_chk("grp first rst", grp_base(0) + agg_addr_t'(4 * k), '0);
			rd_chk("grp last rst", grp_base(18) + agg_addr_t'(4 * k), '0);
		end
		for (int k = 0; k < 5; k++) begin
			rd_chk("block rst", `AGG_BLK_EN_SET + agg_addr_t'(4 * k), '0);
		end
		rd_chk("unmapped", 12'h3fc, '0);
		$display("reset test done");
		for (int gi = 0; gi < `AGG_GRP_NUM; gi++) begin
			if (gi == 0) begin
				one_group(gi, '1, '1, 32'h0);
			end else if (gi == 18) begin
				one_group(gi, 31'h40000000, 32'hc0000000, 32'h0000ffff);
			end else begin
				one_group(gi, agg_src_t'($random(seed)), $random(seed), $random(seed));
			end
			$display("group test %0d done", gi);
		end
		// sources live in every group, group 0 enabled and requesting, then a reset in mid-run must clear all of it
		@(posedge core_clk);
		src_event <= '1;
		@(posedge core_clk);
		src_event <= '0;
		wr(grp_base(0) + `AGG_OFF_EN_SET, '1);
		wr(`AGG_BLK_EN_SET, '1);
		wr(`AGG_IRQ_MASK, '1);
		settle(2);
		chk_word("req before reset", 32'h00000001, agg_data_t'(core_req_r));
		chk_bit("irq before reset", 1'b1, irq);
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		rd_chk("source after reset", grp_base(18) + `AGG_OFF_SRC, '0);
		rd_chk("enable after reset", grp_base(0) + `AGG_OFF_EN_SET, '0);
		rd_chk("block after reset", `AGG_BLK_EN_SET, '0);
		rd_chk("status after reset", `AGG_IRQ_STATUS, '0);
		rd_chk("mask after reset", `AGG_IRQ_MASK, '0);
		chk_word("req after reset", '0, agg_data_t'(core_req_r));
		chk_bit("irq after reset", 1'b0, irq);
		$display("mid-run reset test done");
		report_and_stop();
	end
	// hang guard
	initial begin
		repeat (50000) @(posedge core_clk);
		n_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== hdl/agg_group.sv ====
// Purpose: one aggregated group: sticky sources, enables, result
// Assumes: events are same-clock pulses or levels
// Notes: unimplemented bits are forced to zero by IMPL_MASK
`include "agg_consts.svh"
`default_nettype none
module agg_group
	import agg_pkg::*;
#(
	parameter agg_src_t IMPL_MASK = '1
) (
	input wire logic core_clk,
	input wire logic srst,
	agg_grp_if.grp bus
);
	agg_src_t src_r;
	agg_src_t en_r;
	agg_src_t src_clr;

	// ******************************
	// sticky source and enable state
	// ******************************
	// clear only where a one is written
	assign src_clr = bus.src_clr_wr ? bus.wdata : `AGG_RST_SRC;

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			src_r <= `AGG_RST_SRC;
		end else begin
			src_r <= ((src_r & ~src_clr) | bus.event_in) & IMPL_MASK;
		end
	end

	// single enable flop per bit, touched only by the two ports
	always_ff @(posedge core_clk) begin
		if (srst) begin
			en_r <= `AGG_RST_SRC;
		end else if (bus.en_set_wr) begin
			en_r <= (en_r | bus.wdata) & IMPL_MASK;
		end else if (bus.en_clr_wr) begin
			en_r <= en_r & ~bus.wdata;
		end
	end

	assign bus.src = src_r;
	assign bus.en = en_r;
	assign bus.result = src_r & en_r;

	// ******************************
	// checks
	// ******************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_src_sticky_hold: assert property (!bus.src_clr_wr |=>
		((src_r & $past(src_r)) == $past(src_r)))
		else $error("source flag dropped without a clear");
	a_event_latched: assert property ((|bus.event_in) |=>
		((src_r & $past(bus.event_in & IMPL_MASK)) == $past(bus.event_in & IMPL_MASK)))
		else $error("event not latched into source");
	a_enable_port_only: assert property (!(bus.en_set_wr || bus.en_clr_wr) |=>
		$stable(en_r))
		else $error("enable changed without a port write");
	a_reserved_bits_zero: assert property (((src_r | en_r) & ~IMPL_MASK) == '0)
		else $error("reserved group bit set");
endmodule
`default_nettype wire

// ==== hdl/agg_irq_ctl.sv ====
// Purpose: sticky status, mask and level interrupt for group requests
// Assumes: set pulses come from the same clock
// Notes: interrupt output lags the status by one cycle
`include "agg_consts.svh"
`default_nettype none
module agg_irq_ctl
	import agg_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire agg_grp_t set_evt,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire agg_grp_t wdata,
	output agg_grp_t status,
	output agg_grp_t mask,
	output logic irq
);
	// ******************************
	// status, mask, output
	// ******************************
	// write-one-to-clear, a new event beats the clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			status <= `AGG_RST_GRP;
		end else begin
			status <= (status & ~(clr_wr ? wdata : `AGG_RST_GRP)) | set_evt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			mask <= `AGG_RST_GRP;
		end else if (mask_wr) begin
			mask <= wdata;
		end
	end

	// registered so the pin never glitches
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	a_irq_level: assert property (@(posedge core_clk) disable iff (srst)
		1'b1 |=> (irq == $past(|(status & mask))))
		else $error("interrupt level does not follow masked status");
endmodule
`default_nettype wire

// ==== hdl/agg_top.sv ====
// Purpose: interrupt group aggregator with its register port
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes: group n window starts at n times the group stride
//
// Summary of operation
// - each source bit is sticky on its event, cleared by writing one
// - sources record events regardless of the per-bit enable
// - unassigned bits of the four group registers read zero
// - bits of pins absent in a package variant behave as reserved
// - writing one to enable-set sets that enable, zero does nothing
// - writing one to enable-clear clears that enable, zero does nothing
// - enable-set and enable-clear both read the one enable bit
// - exactly one enable flop per bit, changed only by set and clear
// - result bit is one only when source and enable are both one
// - result register is read-only, writes change nothing
// - writing one to block enable-set enables that group's request
// - writing one to block enable-clear disables that group's request
// - vector shows asserted group requests, disabled groups read zero
`include "agg_consts.svh"
`default_nettype none
module agg_top
	import agg_pkg::*;
#(
	// bits with an interrupt assigned, per group
	parameter logic [`AGG_GRP_NUM*`AGG_SRC_W-1:0] ASSIGNED_MASK = '1,
	// bits whose pin is bonded out in this package
	parameter logic [`AGG_GRP_NUM*`AGG_SRC_W-1:0] PIN_MASK = '1
) (
	input wire logic core_clk,
	input wire logic srst,
	input wire agg_addr_t reg_addr,
	input wire agg_data_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output agg_data_t reg_rdata_r,
	input wire logic [`AGG_GRP_NUM*`AGG_SRC_W-1:0] src_event,
	output agg_grp_t core_req_r,
	output logic irq
);
	// ******************************
	// address decode
	// ******************************
	// true when addr hits register kind k of group g
	function automatic logic reg_hit(input agg_addr_t a, input int unsigned g,
			input agg_kind_e k);
		agg_addr_t off;
		off = `AGG_OFF_SRC;
		case (k)
			AGG_KIND_SRC: off = `AGG_OFF_SRC;
			AGG_KIND_EN_SET: off = `AGG_OFF_EN_SET;
			AGG_KIND_RESULT: off = `AGG_OFF_RESULT;
			AGG_KIND_EN_CLR: off = `AGG_OFF_EN_CLR;
		endcase
		return a == (agg_addr_t'(g) * `AGG_GRP_STRIDE + off);
	endfunction

	// block-level field taken from a bus word
	function automatic agg_grp_t vec_field(input agg_data_t d);
		return d[`AGG_VEC_MSB:`AGG_VEC_LSB];
	endfunction

	// block-level field placed into a bus word, rest reserved zero
	function automatic agg_data_t vec_word(input agg_grp_t v);
		agg_data_t w;
		w = `AGG_RST_WORD;
		w[`AGG_VEC_MSB:`AGG_VEC_LSB] = v;
		return w;
	endfunction

	agg_src_t src_a [`AGG_GRP_NUM];
	agg_src_t en_a [`AGG_GRP_NUM];
	agg_src_t res_a [`AGG_GRP_NUM];
	agg_grp_t any_res;
	agg_grp_t blk_en_r;
	agg_grp_t core_req_nxt;
	agg_grp_t req_rise;
	agg_grp_t irq_status;
	agg_grp_t irq_mask;
	agg_data_t rd_mux;
	logic blk_set_wr;
	logic blk_clr_wr;
	logic stat_clr_wr;
	logic mask_wr;

	assign blk_set_wr = reg_wr && (reg_addr == `AGG_BLK_EN_SET);
	assign blk_clr_wr = reg_wr && (reg_addr == `AGG_BLK_EN_CLR);
	assign stat_clr_wr = reg_wr && (reg_addr == `AGG_IRQ_STATUS);
	assign mask_wr = reg_wr && (reg_addr == `AGG_IRQ_MASK);

	// ******************************
	// group instances
	// ******************************
	// result window has no write strobe at all, so writes there are inert
	for (genvar g = 0; g < `AGG_GRP_NUM; g++) begin : gen_grp
		agg_grp_if #(.W(`AGG_SRC_W)) gi ();

		assign gi.src_clr_wr = reg_wr && reg_hit(reg_addr, g, AGG_KIND_SRC);
		assign gi.en_set_wr = reg_wr && reg_hit(reg_addr, g, AGG_KIND_EN_SET);
		assign gi.en_clr_wr = reg_wr && reg_hit(reg_addr, g, AGG_KIND_EN_CLR);
		assign gi.wdata = reg_wdata[`AGG_SRC_W-1:0];
		assign gi.event_in = src_event[g*`AGG_SRC_W +: `AGG_SRC_W];

		agg_group #(
			.IMPL_MASK(ASSIGNED_MASK[g*`AGG_SRC_W +: `AGG_SRC_W] &
				PIN_MASK[g*`AGG_SRC_W +: `AGG_SRC_W])
		) u_grp (
			.core_clk(core_clk),
			.srst(srst),
			.bus(gi)
		);

		assign src_a[g] = gi.src;
		assign en_a[g] = gi.en;
		assign res_a[g] = gi.result;
		assign any_res[g] = |gi.result;
	end

	// ******************************
	// block-level group enables
	// ******************************
	// set and clear sit at different addresses, so never both at once
	always_ff @(posedge core_clk) begin
		if (srst) begin
			blk_en_r <= `AGG_RST_GRP;
		end else if (blk_set_wr) begin
			blk_en_r <= blk_en_r | vec_field(reg_wdata);
		end else if (blk_clr_wr) begin
			blk_en_r <= blk_en_r & ~vec_field(reg_wdata);
		end
	end

	// ******************************
	// requests toward the core controller
	// ******************************
	assign core_req_nxt = blk_en_r & any_res;
	assign req_rise = core_req_nxt & ~core_req_r;

	// flop keeps the request pins free of decode glitches
	always_ff @(posedge core_clk) begin
		if (srst) begin
			core_req_r <= `AGG_RST_GRP;
		end else begin
			core_req_r <= core_req_nxt;
		end
	end

	// ******************************
	// local interrupt on new group requests
	// ******************************
	agg_irq_ctl u_irq (
		.core_clk(core_clk),
		.srst(srst),
		.set_evt(req_rise),
		.clr_wr(stat_clr_wr),
		.mask_wr(mask_wr),
		.wdata(vec_field(reg_wdata)),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// ******************************
	// read path
	// ******************************
	// unmapped addresses and reserved bits read zero
	always_comb begin
		rd_mux = `AGG_RST_WORD;
		for (int unsigned g = 0; g < `AGG_GRP_NUM; g++) begin
			if (reg_hit(reg_addr, g, AGG_KIND_SRC)) begin
				rd_mux[`AGG_SRC_W-1:0] = src_a[g];
			end
			if (reg_hit(reg_addr, g, AGG_KIND_EN_SET) ||
					reg_hit(reg_addr, g, AGG_KIND_EN_CLR)) begin
				rd_mux[`AGG_SRC_W-1:0] = en_a[g];
			end
			if (reg_hit(reg_addr, g, AGG_KIND_RESULT)) begin
				rd_mux[`AGG_SRC_W-1:0] = res_a[g];
			end
		end
		unique case (reg_addr)
			`AGG_BLK_EN_SET,
			`AGG_BLK_EN_CLR: rd_mux = vec_word(blk_en_r);
			`AGG_BLK_VECTOR: rd_mux = vec_word(core_req_r);
			`AGG_IRQ_STATUS: rd_mux = vec_word(irq_status);
			`AGG_IRQ_MASK: rd_mux = vec_word(irq_mask);
			default: ;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			reg_rdata_r <= `AGG_RST_WORD;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_mux;
		end else begin
			reg_rdata_r <= `AGG_RST_WORD;
		end
	end

	// ******************************
	// checks
	// ******************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_rd_idle_zero: assert property (!reg_rd |=> (reg_rdata_r == `AGG_RST_WORD))
		else $error("read data outside the answer cycle");
	a_rsv_bit_zero: assert property (reg_rd |=> !reg_rdata_r[`AGG_RSV_BIT])
		else $error("reserved bit read as one");
	a_vec_readback: assert property ((reg_rd && reg_addr == `AGG_BLK_VECTOR) |=>
		(vec_field(reg_rdata_r) == $past(core_req_r)))
		else $error("vector read does not show requests");
	a_grp_disabled: assert property (1'b1 |=>
		((core_req_r & ~$past(blk_en_r)) == `AGG_RST_GRP))
		else $error("disabled group asserted a request");
	a_blk_set_ones: assert property (blk_set_wr |=>
		((blk_en_r & $past(vec_field(reg_wdata))) == $past(vec_field(reg_wdata))))
		else $error("group enable set did not take");
	a_blk_clr_ones: assert property (blk_clr_wr |=>
		((blk_en_r & $past(vec_field(reg_wdata))) == `AGG_RST_GRP))
		else $error("group enable clear did not take");
	a_blk_hold: assert property (!(blk_set_wr || blk_clr_wr) |=> $stable(blk_en_r))
		else $error("group enable moved without a write");
	a_req_follows: assert property ((blk_en_r[0] && any_res[0]) ##1
		(blk_en_r[0] && any_res[0]) |-> core_req_r[0])
		else $error("enabled group with result not requesting");

	c_vec_read: cover property ((reg_rd && reg_addr == `AGG_BLK_VECTOR) ##1
		(reg_rdata_r != `AGG_RST_WORD));
	c_req_raise: cover property ($rose(core_req_r[0]) ##[1:20] irq);
	c_blk_clr_drop: cover property (core_req_r[0] ##1 blk_clr_wr ##2 !core_req_r[0]);
endmodule
`default_nettype wire

// ==== inc/agg_consts.svh ====
// Purpose: constants of the interrupt group aggregator
// Assumes: byte addresses on a 12-bit register port
// Notes: group n occupies one stride, n counted from the first group
`ifndef AGG_CONSTS_SVH
`define AGG_CONSTS_SVH
`define AGG_ADDR_W 12
`define AGG_DATA_W 32
`define AGG_SRC_W 31
`define AGG_GRP_NUM 19
`define AGG_VEC_LSB 8
`define AGG_VEC_MSB 26
`define AGG_RSV_BIT 31
// per-group register window
`define AGG_GRP_STRIDE 12'h014
`define AGG_OFF_SRC 12'h000
`define AGG_OFF_EN_SET 12'h004
`define AGG_OFF_RESULT 12'h008
`define AGG_OFF_EN_CLR 12'h00c
// block-level registers
`define AGG_BLK_EN_SET 12'h200
`define AGG_BLK_EN_CLR 12'h204
`define AGG_BLK_VECTOR 12'h208
`define AGG_IRQ_STATUS 12'h20c
`define AGG_IRQ_MASK 12'h210
// reset values
`define AGG_RST_SRC 31'h0
`define AGG_RST_GRP 19'h0
`define AGG_RST_WORD 32'h0
`endif

// ==== inc/agg_grp_if.sv ====
// Purpose: link between the register decoder and one group
// Assumes: one clock, write strobes are one cycle
// Notes: ctl side drives writes and events, grp side returns state
`default_nettype none
interface agg_grp_if #(
	parameter int W = 31
);
	logic src_clr_wr;
	logic en_set_wr;
	logic en_clr_wr;
	logic [W-1:0] wdata;
	logic [W-1:0] event_in;
	logic [W-1:0] src;
	logic [W-1:0] en;
	logic [W-1:0] result;
	modport ctl (
		output src_clr_wr, en_set_wr, en_clr_wr, wdata, event_in,
		input src, en, result
	);
	modport grp (
		input src_clr_wr, en_set_wr, en_clr_wr, wdata, event_in,
		output src, en, result
	);
endinterface
`default_nettype wire

// ==== inc/agg_pkg.sv ====
// Purpose: shared types of the interrupt group aggregator
// Assumes: agg_consts.svh holds every number
// Notes: none
`include "agg_consts.svh"
`default_nettype none
package agg_pkg;
	typedef logic [`AGG_SRC_W-1:0] agg_src_t;
	typedef logic [`AGG_GRP_NUM-1:0] agg_grp_t;
	typedef logic [`AGG_ADDR_W-1:0] agg_addr_t;
	typedef logic [`AGG_DATA_W-1:0] agg_data_t;
	// register kinds inside one group window
	typedef enum logic [1:0] {
		AGG_KIND_SRC,
		AGG_KIND_EN_SET,
		AGG_KIND_RESULT,
		AGG_KIND_EN_CLR
	} agg_kind_e;
endpackage
`default_nettype wire
